// ===== rtl/bst_cfg.svh
// boundary-scan tap constants: instruction codes, cell layout, sizes
`ifndef BST_CFG_SVH
`define BST_CFG_SVH

// instruction register
`define BST_IR_W       3
`define BST_IR_EXTEST  3'h0
`define BST_IR_SAMPLE  3'h1
`define BST_IR_USER1   3'h2
`define BST_IR_USER2   3'h3
`define BST_IR_RDBK    3'h4
`define BST_IR_CONFIG  3'h5
`define BST_IR_BYPASS  3'h7
// pattern loaded in capture-ir, low bits 01
`define BST_IR_CAPT    3'h1

// boundary register layout: three bits per pin_io_cell
`define BST_CELL_BITS  3
`define BST_BIT_IN     0
`define BST_BIT_OUT    1
`define BST_BIT_OE     2

// default number of pin_io_cells, bonded or not
`define BST_N_CELLS    8

`endif

// ===== rtl/bst_pkg.sv
// boundary-scan tap types: controller states and decoded operations
package bst_pkg;

	// sixteen tap controller states
	typedef enum logic [3:0] {
		st_tlr, st_idle,
		st_sel_dr, st_cap_dr, st_sh_dr, st_ex1_dr, st_pa_dr, st_ex2_dr, st_up_dr,
		st_sel_ir, st_cap_ir, st_sh_ir, st_ex1_ir, st_pa_ir, st_ex2_ir, st_up_ir
	} bst_tap_st_t;

	// operation selected after acceptance checks
	typedef enum logic [2:0] {
		op_bypass, op_extest, op_sample, op_user1, op_user2, op_config, op_rdbk
	} bst_op_t;

endpackage

// ===== rtl/bst_sync.sv
// two-flop level synchroniser, one per bit of a vector
`timescale 1ns/1ps
module bst_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         nrst_i,
	input  wire logic         ce_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	logic [W-1:0] meta_r;   // first stage, read only by second
	logic [W-1:0] meta_nxt;
	logic [W-1:0] q_r;      // second stage
	logic [W-1:0] q_nxt;

	////////////////////////////////////////////////////////////////
	// next values: shift when enabled
	always_comb begin
		meta_nxt = meta_r;
		q_nxt    = q_r;
		if (ce_i) begin
			meta_nxt = d_i;
			q_nxt    = meta_r;
		end
	end

	// registers
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			meta_r <= '0;
			q_r    <= '0;
		end else begin
			meta_r <= meta_nxt;
			q_r    <= q_nxt;
		end
	end

	assign q_o = q_r;

endmodule // bst_sync

// ===== rtl/bst_tap_fsm.sv
// sixteen-state tap controller stepped by tms on rising tck
`timescale 1ns/1ps
module bst_tap_fsm
	import bst_pkg::*;
(
	input  wire logic  tck_i,
	input  wire logic  nrst_i,
	input  wire logic  ce_i,
	input  wire logic  force_rst_i,  // hold in test-logic-reset
	input  wire logic  tms_i,
	output bst_tap_st_t state_o
);

	bst_tap_st_t st_r;   // current state
	bst_tap_st_t st_nxt; // next state

	////////////////////////////////////////////////////////////////
	// next-state table, tms high walks toward reset
	always_comb begin
		case (st_r)
			st_tlr:    st_nxt = tms_i ? st_tlr    : st_idle;
			st_idle:   st_nxt = tms_i ? st_sel_dr : st_idle;
			st_sel_dr: st_nxt = tms_i ? st_sel_ir : st_cap_dr;
			st_cap_dr: st_nxt = tms_i ? st_ex1_dr : st_sh_dr;
			st_sh_dr:  st_nxt = tms_i ? st_ex1_dr : st_sh_dr;
			st_ex1_dr: st_nxt = tms_i ? st_up_dr  : st_pa_dr;
			st_pa_dr:  st_nxt = tms_i ? st_ex2_dr : st_pa_dr;
			st_ex2_dr: st_nxt = tms_i ? st_up_dr  : st_sh_dr;
			st_up_dr:  st_nxt = tms_i ? st_sel_dr : st_idle;
			st_sel_ir: st_nxt = tms_i ? st_tlr    : st_cap_ir;
			st_cap_ir: st_nxt = tms_i ? st_ex1_ir : st_sh_ir;
			st_sh_ir:  st_nxt = tms_i ? st_ex1_ir : st_sh_ir;
			st_ex1_ir: st_nxt = tms_i ? st_up_ir  : st_pa_ir;
			st_pa_ir:  st_nxt = tms_i ? st_ex2_ir : st_pa_ir;
			st_ex2_ir: st_nxt = tms_i ? st_up_ir  : st_sh_ir;
			st_up_ir:  st_nxt = tms_i ? st_sel_dr : st_idle;
			default:   st_nxt = st_tlr;
		endcase
		if (force_rst_i) begin
			st_nxt = st_tlr;
		end
	end

	// state register, frozen while ce is low
	always_ff @(posedge tck_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_r <= st_tlr;
		end else if (ce_i) begin
			st_r <= st_nxt;
		end
	end

	assign state_o = st_r;

endmodule // bst_tap_fsm

// ===== rtl/bst_boundary_scan_top.sv
// boundary-scan test logic: tap, instruction and data registers, pin cells
`timescale 1ns/1ps
`include "bst_cfg.svh"

// Functional notes
// - tap runs extest, sample/preload and bypass
// - two user-code instructions also decoded
// - scan option dedicates three inputs, one output
// - every pin_io_cell scanned as bidirectional pin
// - scan independent of cell configuration, package
// - extest captures core drive of any cell
// - four scan pins, no test reset pin
// - sixteen-state controller, instruction, data registers
// - three boundary bits per cell: in, out, enable
// - public always before config, later if enabled
// - sample, bypass still work during configuration
// - scan path loads config, reads memory back
// - user register gets reset, update, shift strobes
// - scan inputs still reach user logic
// - unconfigured non-config outputs float, pulled up
// - unused cells after config: input, pulled up
module bst_boundary_scan_top
	import bst_pkg::*;
#(
	parameter int N = `BST_N_CELLS  // pin_io_cells incl. unbonded
) (
	input  wire logic         sys_clk_i,
	input  wire logic         nrst_i,
	input  wire logic         ce_i,
	input  wire logic         tck_i,        // scan clock, own domain
	input  wire logic         tms_i,
	input  wire logic         tdi_i,
	output logic              tdo_o,
	output logic              tdo_oe_o,
	input  wire logic         bscan_sel_i,  // scan option selected
	input  wire logic         cfg_busy_i,   // configuration in progress
	input  wire logic         cfg_done_i,   // configuration complete
	input  wire logic         scan_en_i,    // design enables public instr
	input  wire logic         user_en_i,    // design enables user codes
	input  wire logic [N-1:0] pad_in_i,
	input  wire logic [N-1:0] core_out_i,
	input  wire logic [N-1:0] core_oe_i,
	input  wire logic [N-1:0] cell_used_i,
	input  wire logic [N-1:0] cfg_pin_i,    // cell used by configuration
	output logic      [N-1:0] pad_out_o,
	output logic      [N-1:0] pad_oe_o,
	output logic      [N-1:0] pad_pu_o,     // weak pull-up on
	output logic      [N-1:0] core_in_o,
	output logic              user_tms_o,
	output logic              user_tck_o,
	output logic              user_tdi_o,
	output logic              usr_reset_o,
	output logic              usr_update_o,
	output logic              usr_shift_o,
	output logic      [1:0]   usr_sel_o,
	output logic              usr_tdi_o,
	input  wire logic         usr_tdo_i,
	output logic              cfg_bit_o,
	output logic              cfg_bit_vld_o,
	input  wire logic         rb_bit_i,
	output logic              rb_next_o
);

	localparam int BW = `BST_CELL_BITS * N;  // boundary length
	localparam int TW = 3 * N + 7;           // into tck domain
	localparam int SW = 4 * N + 6;           // into sys domain

	////////////////////////////////////////////////////////////////
	// acceptance of the loaded instruction
	function automatic bst_op_t bst_decode(
		input logic [`BST_IR_W-1:0] ir,
		input logic                 busy,
		input logic                 done,
		input logic                 pub_en,
		input logic                 usr_en
	);
		logic pub;
		pub = (!done && !busy) || (done && pub_en);
		case (ir)
			`BST_IR_EXTEST: bst_decode = pub ? op_extest : op_bypass;
			`BST_IR_SAMPLE: bst_decode = (pub || busy) ? op_sample : op_bypass;
			`BST_IR_USER1:  bst_decode = (done && usr_en) ? op_user1 : op_bypass;
			`BST_IR_USER2:  bst_decode = (done && usr_en) ? op_user2 : op_bypass;
			`BST_IR_CONFIG: bst_decode = !done ? op_config : op_bypass;
			`BST_IR_RDBK:   bst_decode = (done && pub_en) ? op_rdbk : op_bypass;
			default:        bst_decode = op_bypass;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////
	// crossings into the tck domain
	logic [TW-1:0] t_q;   // synchronised levels
	logic          ce_t;  // clock enable
	logic          bsel_t, busy_t, done_t, pen_t, uen_t, rb_t;
	logic [N-1:0]  pad_t, cout_t, coe_t;

	bst_sync #(.W(TW)) u_sync_t (
		.clk_i  (tck_i),
		.nrst_i (nrst_i),
		.ce_i   (1'b1),
		.d_i    ({core_oe_i, core_out_i, pad_in_i, rb_bit_i, user_en_i,
		          scan_en_i, cfg_done_i, cfg_busy_i, bscan_sel_i, ce_i}),
		.q_o    (t_q)
	);

	assign ce_t   = t_q[0];
	assign bsel_t = t_q[1];
	assign busy_t = t_q[2];
	assign done_t = t_q[3];
	assign pen_t  = t_q[4];
	assign uen_t  = t_q[5];
	assign rb_t   = t_q[6];
	assign pad_t  = t_q[7 +: N];
	assign cout_t = t_q[7 + N +: N];
	assign coe_t  = t_q[7 + 2 * N +: N];

	////////////////////////////////////////////////////////////////
	// tap controller, held in reset without the scan option
	bst_tap_st_t st;

	bst_tap_fsm u_fsm (
		.tck_i       (tck_i),
		.nrst_i      (nrst_i),
		.ce_i        (ce_t),
		.force_rst_i (!bsel_t),
		.tms_i       (tms_i),
		.state_o     (st)
	);

	////////////////////////////////////////////////////////////////
	// tck rising-edge registers
	logic [`BST_IR_W-1:0] ir_r, ir_nxt;        // active instruction
	logic [`BST_IR_W-1:0] irsh_r, irsh_nxt;    // instruction shifter
	logic [BW-1:0]        bdr_r, bdr_nxt;      // boundary shifter
	logic [BW-1:0]        upd_r, upd_nxt;      // boundary update stage
	logic                 byp_r, byp_nxt;      // bypass bit
	logic                 ext_r, ext_nxt;      // extest active
	logic                 tbit_r, tbit_nxt;    // config bit for sys
	logic                 ctgl_r, ctgl_nxt;    // config bit event
	logic                 rtgl_r, rtgl_nxt;    // readback advance event
	bst_op_t              op;

	assign op = bst_decode(ir_r, busy_t, done_t, pen_t, uen_t);

	// capture, shift and update per state and operation
	always_comb begin
		ir_nxt   = ir_r;
		irsh_nxt = irsh_r;
		bdr_nxt  = bdr_r;
		upd_nxt  = upd_r;
		byp_nxt  = byp_r;
		tbit_nxt = tbit_r;
		ctgl_nxt = ctgl_r;
		rtgl_nxt = rtgl_r;
		ext_nxt  = (op == op_extest);
		case (st)
			st_tlr: begin
				ir_nxt = `BST_IR_BYPASS;
			end
			st_cap_ir: begin
				irsh_nxt = `BST_IR_CAPT;
			end
			st_sh_ir: begin
				irsh_nxt = {tdi_i, irsh_r[`BST_IR_W-1:1]};
			end
			st_up_ir: begin
				ir_nxt = irsh_r;
			end
			st_cap_dr: begin
				byp_nxt = 1'b0;
				if (op == op_extest || op == op_sample) begin
					// every cell the same, whatever its use
					for (int i = 0; i < N; i++) begin
						bdr_nxt[`BST_CELL_BITS*i + `BST_BIT_IN]  = pad_t[i];
						bdr_nxt[`BST_CELL_BITS*i + `BST_BIT_OUT] = cout_t[i];
						bdr_nxt[`BST_CELL_BITS*i + `BST_BIT_OE]  = coe_t[i];
					end
				end
			end
			st_sh_dr: begin
				byp_nxt = tdi_i;
				if (op == op_extest || op == op_sample) begin
					bdr_nxt = {tdi_i, bdr_r[BW-1:1]};
				end
				if (op == op_config) begin
					tbit_nxt = tdi_i;
					ctgl_nxt = !ctgl_r;
				end
				if (op == op_rdbk) begin
					rtgl_nxt = !rtgl_r;
				end
			end
			st_up_dr: begin
				if (op == op_extest || op == op_sample) begin
					upd_nxt = bdr_r;  // preload or drive
				end
			end
			default: begin
			end
		endcase
	end

	// register stage, frozen while ce is low
	always_ff @(posedge tck_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ir_r   <= `BST_IR_BYPASS;
			irsh_r <= '0;
			bdr_r  <= '0;
			upd_r  <= '0;
			byp_r  <= 1'b0;
			ext_r  <= 1'b0;
			tbit_r <= 1'b0;
			ctgl_r <= 1'b0;
			rtgl_r <= 1'b0;
		end else if (ce_t) begin
			ir_r   <= ir_nxt;
			irsh_r <= irsh_nxt;
			bdr_r  <= bdr_nxt;
			upd_r  <= upd_nxt;
			byp_r  <= byp_nxt;
			ext_r  <= ext_nxt;
			tbit_r <= tbit_nxt;
			ctgl_r <= ctgl_nxt;
			rtgl_r <= rtgl_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// tck falling-edge outputs: tdo and user strobes
	logic       tdo_r, tdo_nxt;
	logic       toe_r, toe_nxt;
	logic       urst_r, urst_nxt;
	logic       uupd_r, uupd_nxt;
	logic       ush_r, ush_nxt;
	logic [1:0] usel_r, usel_nxt;
	logic       is_usr;

	assign is_usr = (op == op_user1) || (op == op_user2);

	// selects the serial source, enable only in shift states
	always_comb begin
		case (op)
			op_extest, op_sample: tdo_nxt = bdr_r[0];
			op_user1, op_user2:   tdo_nxt = usr_tdo_i;
			op_rdbk:              tdo_nxt = rb_t;
			default:              tdo_nxt = byp_r;
		endcase
		if (st == st_sh_ir) begin
			tdo_nxt = irsh_r[0];
		end
		toe_nxt  = bsel_t && (st == st_sh_dr || st == st_sh_ir);
		urst_nxt = (st == st_tlr);
		uupd_nxt = is_usr && (st == st_up_dr);
		ush_nxt  = is_usr && (st == st_sh_dr);
		usel_nxt = {op == op_user2, op == op_user1};
	end

	// registered on the falling edge
	always_ff @(negedge tck_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tdo_r  <= 1'b0;
			toe_r  <= 1'b0;
			urst_r <= 1'b1;
			uupd_r <= 1'b0;
			ush_r  <= 1'b0;
			usel_r <= 2'h0;
		end else if (ce_t) begin
			tdo_r  <= tdo_nxt;
			toe_r  <= toe_nxt;
			urst_r <= urst_nxt;
			uupd_r <= uupd_nxt;
			ush_r  <= ush_nxt;
			usel_r <= usel_nxt;
		end
	end

	assign tdo_o        = tdo_r;
	assign tdo_oe_o     = toe_r;
	assign usr_reset_o  = urst_r;
	assign usr_update_o = uupd_r;
	assign usr_shift_o  = ush_r;
	assign usr_sel_o    = usel_r;
	assign usr_tdi_o    = tdi_i;

	////////////////////////////////////////////////////////////////
	// crossings into the system domain
	logic [SW-1:0] s_q;
	logic          rtgl_s, ctgl_s, ext_s;
	logic [BW-1:0] upd_s;
	logic [N-1:0]  pad_s;

	bst_sync #(.W(SW)) u_sync_s (
		.clk_i  (sys_clk_i),
		.nrst_i (nrst_i),
		.ce_i   (ce_i),
		.d_i    ({pad_in_i, upd_r, ext_r, ctgl_r, rtgl_r, tdi_i, tck_i, tms_i}),
		.q_o    (s_q)
	);

	assign user_tms_o = s_q[0];
	assign user_tck_o = s_q[1];
	assign user_tdi_o = s_q[2];
	assign rtgl_s     = s_q[3];
	assign ctgl_s     = s_q[4];
	assign ext_s      = s_q[5];
	assign upd_s      = s_q[6 +: BW];
	assign pad_s      = s_q[6 + BW +: N];
	assign core_in_o  = pad_s;

	////////////////////////////////////////////////////////////////
	// system registers: events and pin drive
	logic         cprev_r, cprev_nxt;  // config toggle seen
	logic         rprev_r, rprev_nxt;  // readback toggle seen
	logic         cbit_r, cbit_nxt;
	logic         cvld_r, cvld_nxt;
	logic         rnext_r, rnext_nxt;
	logic [N-1:0] pout_r, pout_nxt;
	logic [N-1:0] poe_r, poe_nxt;
	logic [N-1:0] ppu_r, ppu_nxt;

	// toggle edges become one-cycle pulses; per-cell drive choice
	always_comb begin
		cprev_nxt = ctgl_s;
		rprev_nxt = rtgl_s;
		cvld_nxt  = (ctgl_s != cprev_r);
		rnext_nxt = (rtgl_s != rprev_r);
		cbit_nxt  = cbit_r;
		if (ctgl_s != cprev_r) begin
			cbit_nxt = tbit_r;  // stable for a whole tck period
		end
		for (int i = 0; i < N; i++) begin
			if (ext_s) begin
				pout_nxt[i] = upd_s[`BST_CELL_BITS*i + `BST_BIT_OUT];
				poe_nxt[i]  = upd_s[`BST_CELL_BITS*i + `BST_BIT_OE];
				ppu_nxt[i]  = 1'b0;
			end else if (!cfg_done_i && !cfg_pin_i[i]) begin
				pout_nxt[i] = 1'b1;  // float with pull-up
				poe_nxt[i]  = 1'b0;
				ppu_nxt[i]  = 1'b1;
			end else if (cfg_done_i && !cell_used_i[i]) begin
				pout_nxt[i] = 1'b1;  // unused input
				poe_nxt[i]  = 1'b0;
				ppu_nxt[i]  = 1'b1;
			end else begin
				pout_nxt[i] = core_out_i[i];
				poe_nxt[i]  = core_oe_i[i];
				ppu_nxt[i]  = 1'b0;
			end
		end
	end

	// registers, frozen while ce is low
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cprev_r <= 1'b0;
			rprev_r <= 1'b0;
			cbit_r  <= 1'b0;
			cvld_r  <= 1'b0;
			rnext_r <= 1'b0;
			pout_r  <= '1;
			poe_r   <= '0;
			ppu_r   <= '1;
		end else if (ce_i) begin
			cprev_r <= cprev_nxt;
			rprev_r <= rprev_nxt;
			cbit_r  <= cbit_nxt;
			cvld_r  <= cvld_nxt;
			rnext_r <= rnext_nxt;
			pout_r  <= pout_nxt;
			poe_r   <= poe_nxt;
			ppu_r   <= ppu_nxt;
		end
	end

	assign cfg_bit_o     = cbit_r;
	assign cfg_bit_vld_o = cvld_r;
	assign rb_next_o     = rnext_r;
	assign pad_out_o     = pout_r;
	assign pad_oe_o      = poe_r;
	assign pad_pu_o      = ppu_r;

endmodule // bst_boundary_scan_top

// ===== test/bst_tap_monitor.sv
// assertion checker on the boundary-scan tap top ports
`timescale 1ns/1ps
module bst_tap_monitor #(
	parameter int N = 8  // cell count
) (
	input wire logic         sys_clk_i,
	input wire logic         nrst_i,
	input wire logic         ce_i,
	input wire logic         tck_i,
	input wire logic         tms_i,
	input wire logic         bscan_sel_i,
	input wire logic         tdo_oe_o,
	input wire logic [N-1:0] pad_in_i,
	input wire logic [N-1:0] core_in_o,
	input wire logic         usr_reset_o,
	input wire logic         usr_update_o,
	input wire logic         usr_shift_o,
	input wire logic [1:0]   usr_sel_o,
	input wire logic         cfg_bit_vld_o,
	input wire logic         rb_next_o
);
//////////////////////////////////////////////////
	// tck domain: strobes are falling-edge flops, seen at rising
	property p_tms_reset;
		@(posedge tck_i) disable iff (!nrst_i)
		(tms_i && ce_i && bscan_sel_i) [*5] |-> ##1 usr_reset_o;
	endproperty
	a_tms_reset: assert property (p_tms_reset) else $error("no reset after tms highs");
	property p_shift_oe;
		@(posedge tck_i) disable iff (!nrst_i)
		usr_shift_o |-> tdo_oe_o && (usr_sel_o != 2'h0);
	endproperty
	a_shift_oe: assert property (p_shift_oe) else $error("user shift without drive");
	property p_upd_one;
		@(posedge tck_i) disable iff (!nrst_i)
		usr_update_o |=> !usr_update_o && !usr_shift_o;
	endproperty
	a_upd_one: assert property (p_upd_one) else $error("update strobe too long");
	property p_sel_one;
		@(posedge tck_i) disable iff (!nrst_i)
		$onehot0(usr_sel_o);
	endproperty
	a_sel_one: assert property (p_sel_one) else $error("two user codes at once");
	property p_rst_quiet;
		@(posedge tck_i) disable iff (!nrst_i)
		usr_reset_o |-> !tdo_oe_o && !usr_shift_o && !usr_update_o;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("activity in reset state");
//////////////////////////////////////////////////
	// sys domain: pulses and pin input path
	property p_vld;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		cfg_bit_vld_o |=> !cfg_bit_vld_o;
	endproperty
	a_vld: assert property (p_vld) else $error("config strobe too long");
	property p_rbn;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		rb_next_o |=> !rb_next_o;
	endproperty
	a_rbn: assert property (p_rbn) else $error("readback strobe too long");
	property p_core_in;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		$past(nrst_i) && $past(nrst_i, 2) && $past(ce_i) && $past(ce_i, 2)
		|-> core_in_o == $past(pad_in_i, 2);
	endproperty
	a_core_in: assert property (p_core_in) else $error("pin level not passed on");
	// main scenarios reached
	c_upd: cover property (@(posedge tck_i) usr_update_o);
	c_vld: cover property (@(posedge sys_clk_i) cfg_bit_vld_o);
	c_rbn: cover property (@(posedge sys_clk_i) rb_next_o);
endmodule // bst_tap_monitor

bind bst_boundary_scan_top bst_tap_monitor #(.N(N)) u_bst_tap_monitor (
	.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .tck_i(tck_i),
	.tms_i(tms_i), .bscan_sel_i(bscan_sel_i), .tdo_oe_o(tdo_oe_o),
	.pad_in_i(pad_in_i), .core_in_o(core_in_o), .usr_reset_o(usr_reset_o),
	.usr_update_o(usr_update_o), .usr_shift_o(usr_shift_o), .usr_sel_o(usr_sel_o),
	.cfg_bit_vld_o(cfg_bit_vld_o), .rb_next_o(rb_next_o)
);

// ===== test/bst_jtag_host.sv
// far-end scan controller model: drives tck, tms, tdi, reads tdo
`timescale 1ns/1ps
module bst_jtag_host (
	output logic      tck_o,
	output logic      tms_o,
	output logic      tdi_o,
	input  wire logic tdo_i,
	input  wire logic tdo_oe_i
);
	logic last_r;  // last level seen on tdo
	initial begin
		tck_o = 1'b0;  // tck stands still between frames
		tms_o = 1'b1;  // idle high keeps tap in reset
		tdi_o = 1'b0;
		last_r = 1'b0;
	end
//////////////////////////////////////////////////
	// one 125 ns tck period; tdo read just before rising edge
	task automatic tick(input logic m, input logic d, output logic o);
		tms_o = m;
		tdi_o = d;
		#31;
		o = tdo_oe_i ? tdo_i : ~last_r;  // released line reads inverted
		last_r = o;
		tck_o = 1'b1;
		#62.5;
		tck_o = 1'b0;
		#31.5;
	endtask
	// five tms highs, then park in idle
	task automatic reset_tap();
		logic o;
		repeat (5) tick(1'b1, 1'b0, o);
		tick(1'b0, 1'b0, o);
	endtask
	// idle -> capture -> shift n bits lsb first -> update -> idle
	task automatic scan(input logic ir, input int n, input logic [31:0] din,
		output logic [31:0] dout);
		logic o;
		dout = '0;
		tick(1'b1, 1'b0, o);
		if (ir) begin
			tick(1'b1, 1'b0, o);
		end
		tick(1'b0, 1'b0, o);  // capture
		tick(1'b0, 1'b0, o);  // enter shift
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], o);
			dout[i] = o;
		end
		tick(1'b1, 1'b0, o);  // update
		tick(1'b0, 1'b0, o);  // idle
	endtask
endmodule // bst_jtag_host

// ===== test/bst_boundary_scan_top_bench.sv
// self-checking bench for the boundary-scan tap
`timescale 1ns/1ps
`include "bst_cfg.svh"
module bst_boundary_scan_top_bench;
	localparam int N = 4;  // small cell count
	localparam int CB = N * `BST_CELL_BITS;  // chain length
	logic sys_clk_i, nrst_i, ce_i, bscan_sel_i, cfg_busy_i, cfg_done_i;
	logic scan_en_i, user_en_i, usr_tdo_i, rb_bit_i, tck_i, tms_i, tdi_i;
	logic tdo_o, tdo_oe_o, user_tms_o, user_tck_o, user_tdi_o, usr_reset_o;
	logic usr_update_o, usr_shift_o, usr_tdi_o, cfg_bit_o, cfg_bit_vld_o, rb_next_o;
	logic [1:0]   usr_sel_o;
	logic [N-1:0] pad_in_i, core_out_i, core_oe_i, cell_used_i, cfg_pin_i;
	logic [N-1:0] pad_out_o, pad_oe_o, pad_pu_o, core_in_o;
	logic [7:0]   cfg_q;  // config bits collected
	int           n_errors, compares, cyc, n_cfg, n_rb;
	bst_boundary_scan_top #(.N(N)) u_bst_boundary_scan_top (
		.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .tck_i(tck_i),
		.tms_i(tms_i), .tdi_i(tdi_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
		.bscan_sel_i(bscan_sel_i), .cfg_busy_i(cfg_busy_i), .cfg_done_i(cfg_done_i),
		.scan_en_i(scan_en_i), .user_en_i(user_en_i), .pad_in_i(pad_in_i),
		.core_out_i(core_out_i), .core_oe_i(core_oe_i), .cell_used_i(cell_used_i),
		.cfg_pin_i(cfg_pin_i), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o),
		.pad_pu_o(pad_pu_o), .core_in_o(core_in_o), .user_tms_o(user_tms_o),
		.user_tck_o(user_tck_o), .user_tdi_o(user_tdi_o), .usr_reset_o(usr_reset_o),
		.usr_update_o(usr_update_o), .usr_shift_o(usr_shift_o), .usr_sel_o(usr_sel_o),
		.usr_tdi_o(usr_tdi_o), .usr_tdo_i(usr_tdo_i), .cfg_bit_o(cfg_bit_o),
		.cfg_bit_vld_o(cfg_bit_vld_o), .rb_bit_i(rb_bit_i), .rb_next_o(rb_next_o)
	);
	bst_jtag_host u_bst_jtag_host (.tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i),
		.tdo_i(tdo_o), .tdo_oe_i(tdo_oe_o));
//////////////////////////////////////////////////
	always #12.5 sys_clk_i = ~sys_clk_i;
	// count config and readback strobes; cut a hang short
	always @(posedge sys_clk_i) begin
		if (cfg_bit_vld_o === 1'b1) begin
			cfg_q <= {cfg_bit_o, cfg_q[7:1]};
			n_cfg <= n_cfg + 1;
		end
		if (rb_next_o === 1'b1) begin
			n_rb <= n_rb + 1;
		end
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			test_done();
		end
	end
//////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task test_done();
		$display("compares=%0d n_errors=%0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// expected chain: in, out, enable per cell
	function automatic logic [31:0] chain(input logic [N-1:0] p, o, e);
		chain = '0;
		for (int i = 0; i < N; i++) begin
			chain[`BST_CELL_BITS*i+`BST_BIT_IN] = p[i];
			chain[`BST_CELL_BITS*i+`BST_BIT_OUT] = o[i];
			chain[`BST_CELL_BITS*i+`BST_BIT_OE] = e[i];
		end
	endfunction
	task automatic set_cfg(input logic b, dn, s, u);
		@(negedge sys_clk_i);
		cfg_busy_i = b;
		cfg_done_i = dn;
		scan_en_i = s;
		user_en_i = u;
	endtask
	task automatic settle();
		repeat (8) @(negedge sys_clk_i);
	endtask
	task automatic ld(input logic [2:0] code);
		logic [31:0] d;
		u_bst_jtag_host.scan(1'b1, `BST_IR_W, {29'h0, code}, d);
		check(d[2:0], `BST_IR_CAPT);
	endtask
	task automatic dr(input int n, input logic [31:0] din, output logic [31:0] dout);
		u_bst_jtag_host.scan(1'b0, n, din, dout);
	endtask
//////////////////////////////////////////////////
	task automatic t_bypass();
		logic [31:0] d;
		u_bst_jtag_host.reset_tap();
		dr(8, 32'ha5, d);
		check(d[7:0], 8'h4a);
		ld(`BST_IR_BYPASS);
		dr(4, 32'h9, d);
		check(d[3:0], 4'h2);
		settle();
		check(pad_oe_o, 4'h3);
		check(pad_pu_o, 4'hc);
		check(core_in_o, 4'h6);
		check(user_tms_o, 1'b0);
		check(user_tck_o, 1'b0);
		check(user_tdi_o, 1'b0);
		check(usr_tdi_o, 1'b0);
		$display("test bypass done");
	endtask
	task automatic t_busy();
		logic [31:0] d;
		set_cfg(1'b1, 1'b0, 1'b0, 1'b0);
		ld(`BST_IR_CONFIG);
		n_cfg = 0;
		dr(8, 32'h3c, d);
		settle();
		check(cfg_q, 8'h3c);
		check(n_cfg, 8);
		ld(`BST_IR_EXTEST);
		dr(4, 32'h9, d);
		check(d[3:0], 4'h2);
		$display("test busy done");
	endtask
	task automatic t_scan();
		logic [31:0] d;
		set_cfg(1'b0, 1'b1, 1'b1, 1'b0);
		cell_used_i = 4'hf;
		ld(`BST_IR_SAMPLE);
		dr(CB, 32'h0, d);
		check(d, chain(4'h6, 4'h9, 4'hf));
		ld(`BST_IR_EXTEST);
		dr(CB, chain(4'h0, 4'ha, 4'h3), d);
		check(d, chain(4'h6, 4'h9, 4'hf));
		settle();
		check(pad_out_o, 4'ha);
		check(pad_oe_o, 4'h3);
		cell_used_i = 4'h5;
		u_bst_jtag_host.reset_tap();
		settle();
		check(pad_oe_o, 4'h5);
		check(pad_pu_o, 4'ha);
		check(pad_out_o & 4'h5, 4'h1);
		$display("test scan done");
	endtask
	task automatic t_user();
		logic [31:0] d;
		set_cfg(1'b0, 1'b1, 1'b0, 1'b0);
		ld(`BST_IR_EXTEST);
		dr(4, 32'h9, d);
		check(d[3:0], 4'h2);
		ld(`BST_IR_USER1);
		check(usr_sel_o, 2'h0);
		set_cfg(1'b0, 1'b1, 1'b0, 1'b1);
		usr_tdo_i = 1'b1;
		ld(`BST_IR_USER1);
		check(usr_sel_o, 2'h1);
		dr(4, 32'h0, d);
		check(d[3:0], 4'hf);
		ld(`BST_IR_USER2);
		check(usr_sel_o, 2'h2);
		$display("test user done");
	endtask
	task automatic t_rdbk();
		logic [31:0] d;
		set_cfg(1'b0, 1'b1, 1'b1, 1'b0);
		rb_bit_i = 1'b1;
		ld(`BST_IR_RDBK);
		n_rb = 0;
		dr(4, 32'h0, d);
		settle();
		check(d[3:0], 4'hf);
		check(n_rb, 4);
		@(negedge sys_clk_i);
		bscan_sel_i = 1'b0;
		u_bst_jtag_host.reset_tap();
		dr(4, 32'h0, d);
		check(usr_reset_o, 1'b1);
		check(tdo_oe_o, 1'b0);
		@(negedge sys_clk_i);
		bscan_sel_i = 1'b1;
		$display("test readback done");
	endtask
//////////////////////////////////////////////////
	initial begin
		sys_clk_i = 1'b0;
		nrst_i = 1'b0;
		ce_i = 1'b1;
		bscan_sel_i = 1'b1;
		{cfg_busy_i, cfg_done_i, scan_en_i, user_en_i} = 4'h0;
		usr_tdo_i = 1'b0;
		rb_bit_i = 1'b0;
		pad_in_i = 4'h6;
		core_out_i = 4'h9;
		core_oe_i = 4'hf;
		cell_used_i = 4'h5;
		cfg_pin_i = 4'h3;
		cfg_q = 8'h00;
		{n_errors, compares, cyc, n_cfg, n_rb} = '0;
		repeat (3) @(negedge sys_clk_i);
		nrst_i = 1'b1;
		t_bypass();
		t_busy();
		t_scan();
		t_user();
		t_rdbk();
		test_done();
	end
endmodule // bst_boundary_scan_top_bench
